//--- rtl/mmst_top.sv
`include "mmst_consts.svh"

module mmst_top #(
   parameter int MS_CYCLES = `MMST_CLK_MHZ * `MMST_TICK_US
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               lowpower_request_pin_n,
   input  wire logic               module_rst_pin_n,
   input  wire logic               receive_signal_loss_in,
   input  wire logic               tx_fault_in,
   input  wire logic               tx_los_in,
   output logic                    irq_out_low,
   output logic                    tx_optical_en,
   output logic                    rx_out_en,
   output logic                    reset_state_flag,
   output logic                    lowpower_state_flag,
   output mmst_pkg::mmst_state_e   lane_state
);
   import mmst_pkg::*;

   localparam int RST_MIN_CYC = `MMST_RST_MIN_US * `MMST_CLK_MHZ;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 5'h1F;
         sync2_r <= 5'h1F;
      end else begin
         sync1_r <= {tx_los_in, tx_fault_in, receive_signal_loss_in, module_rst_pin_n,
                     lowpower_request_pin_n};
         sync2_r <= sync1_r;
      end
   end
   wire lp_pin_s    = ~sync2_r[0];
   wire rst_pin_s   = ~sync2_r[1];
   wire receive_signal_loss_s    = sync2_r[2];
   wire tx_fault_s  = sync2_r[3];
   wire tx_los_s    = sync2_r[4];

   logic [2:0] cond_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cond_d_r <= 3'b111;
      else          cond_d_r <= {tx_los_s, tx_fault_s, receive_signal_loss_s};
   end

   // ----------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------
   logic [16:0] div_r;
   wire         tick = (div_r == 17'(MS_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)  div_r <= 17'h0_0000;
      else if (tick) div_r <= 17'h0_0000;
      else           div_r <= div_r + 17'h0_0001;
   end

   // ----------------------------------------------------------------
   // module reset pin filter
   // ----------------------------------------------------------------
   // glitches shorter than the minimum pulse do not reset the module
   logic [9:0] rst_cnt_r;
   wire        mod_rst = (rst_cnt_r == 10'(RST_MIN_CYC));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)        rst_cnt_r <= 10'h000;
      else if (!rst_pin_s) rst_cnt_r <= 10'h000;
      else if (!mod_rst)   rst_cnt_r <= rst_cnt_r + 10'h001;
   end

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   mmst_ctrl_s  ctrl_r;
   mmst_flag_t  flag_r;
   mmst_flag_t  mask_r;
   logic [7:0]  chan_r;
   logic        tune_pend_r;
   mmst_state_e state_r;
   mmst_state_e state_nxt;
   logic        rx_valid;

   wire acc      = psel & penable;
   wire wr_acc   = acc & pwrite;
   wire rd_acc   = acc & ~pwrite;
   wire hit_stat = (paddr == `MMST_OFF_STATUS);
   wire hit_flag = (paddr == `MMST_OFF_FLAGS);
   wire hit_mask = (paddr == `MMST_OFF_MASK);
   wire hit_ctrl = (paddr == `MMST_OFF_CTRL);
   wire hit_chan = (paddr == `MMST_OFF_CHANNEL);
   wire hit_adv  = (paddr == `MMST_OFF_ADV);
   wire hit_any  = hit_stat | hit_flag | hit_mask | hit_ctrl | hit_chan | hit_adv;
   wire flag_rd  = rd_acc & hit_flag;
   wire chan_wr  = wr_acc & hit_chan;

   wire [31:0] stat_word = {24'h00_0000, rx_valid, tx_optical_en,
                            lowpower_state_flag, reset_state_flag, state_r};
   wire [31:0] adv_word  = {`MMST_ADV_TXOFF_MS, `MMST_ADV_TXON_10MS,
                            `MMST_ADV_DEINIT_S, `MMST_ADV_INIT_S};

   assign pready  = 1'b1;
   assign pslverr = acc & ~hit_any;
   assign prdata  = !rd_acc  ? 32'h0000_0000 :
                    hit_stat ? stat_word :
                    hit_flag ? {28'h000_0000, flag_r} :
                    hit_mask ? {28'h000_0000, mask_r} :
                    hit_ctrl ? {26'h000_0000, ctrl_r} :
                    hit_chan ? {24'h00_0000, chan_r} :
                    hit_adv  ? adv_word : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `MMST_RST_CTRL;
         mask_r <= `MMST_RST_MASK;
         chan_r <= `MMST_RST_CHANNEL;
      end else if (wr_acc) begin
         if (hit_ctrl) ctrl_r <= pwdata[5:0];
         if (hit_mask) mask_r <= pwdata[3:0];
         if (hit_chan) chan_r <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // latched flags and interrupt
   // ----------------------------------------------------------------
   wire        state_chg = (state_nxt != state_r);
   mmst_flag_t flag_ev;
   assign flag_ev[`MMST_FLG_RECEIVE_SIGNAL_LOSS]    = receive_signal_loss_s & ~cond_d_r[0];
   assign flag_ev[`MMST_FLG_TX_FAULT]  = tx_fault_s & ~cond_d_r[1];
   assign flag_ev[`MMST_FLG_STATE_CHG] = state_chg;
   assign flag_ev[`MMST_FLG_TX_LOS]    = tx_los_s & ~cond_d_r[2];

   // a set in the read cycle survives the clear
   wire mmst_flag_t flag_nxt = (flag_r & ~{4{flag_rd}}) | flag_ev;
   wire             irq_nxt  = |(flag_nxt & ~mask_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r      <= 4'h0;
         irq_out_low <= 1'b1;
      end else begin
         flag_r      <= flag_nxt;
         irq_out_low <= ~irq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // module and lane path state machine
   // ----------------------------------------------------------------
   function automatic mmst_ms_t state_dur(input mmst_state_e s);
      unique case (s)
         ST_MGMT_INIT:   state_dur = `MMST_MGMT_INIT_MS;
         ST_PWR_UP:      state_dur = `MMST_PWR_UP_MS;
         ST_PATH_INIT:   state_dur = `MMST_PATH_INIT_MS;
         ST_TX_ON:       state_dur = `MMST_TX_ON_MS;
         ST_TX_OFF:      state_dur = `MMST_TX_OFF_MS;
         ST_TUNE:        state_dur = `MMST_TUNE_MS;
         ST_PATH_DEINIT: state_dur = `MMST_PATH_DEINIT_MS;
         ST_PWR_DN:      state_dur = `MMST_PWR_DN_MS;
         default:        state_dur = 16'h0000;
      endcase
   endfunction

   mmst_ms_t timer_r;
   wire      [15:0] dur  = state_dur(state_r);
   wire      done        = tick & (dur != 16'h0000) & (timer_r == dur - 16'h0001);
   wire      lp_req      = lp_pin_s | ctrl_r.forced_lowpower_ctrl;
   wire      high_pwr    = (state_r != ST_MGMT_INIT) & (state_r != ST_LOW_PWR) &
                           (state_r != ST_PWR_DN);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_MGMT_INIT:   if (done) state_nxt = lp_req ? ST_LOW_PWR : ST_PWR_UP;
         ST_LOW_PWR:     if (!lp_req) state_nxt = ST_PWR_UP;
         ST_PWR_UP:      if (done) state_nxt = ST_PATH_INIT;
         ST_PATH_INIT:   if (done) state_nxt = ST_TX_ON;
         ST_TX_ON:       if (done) state_nxt = ST_ACTIVE;
         ST_ACTIVE:      if (ctrl_r.path_deinit | tune_pend_r) state_nxt = ST_TX_OFF;
         ST_TX_OFF:      if (done) state_nxt = tune_pend_r ? ST_TUNE : ST_PATH_DEINIT;
         ST_TUNE:        if (done) state_nxt = ST_TX_ON;
         ST_PATH_DEINIT: if (done) state_nxt = ST_PATH_OFF;
         ST_PATH_OFF:    if (!ctrl_r.path_deinit) state_nxt = ST_PATH_INIT;
         ST_PWR_DN:      if (done) state_nxt = ST_LOW_PWR;
         default:        state_nxt = ST_MGMT_INIT;
      endcase
      if (high_pwr && lp_req) state_nxt = ST_PWR_DN;
      if (mod_rst) state_nxt = ST_MGMT_INIT;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_MGMT_INIT;
         timer_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         if (state_chg || mod_rst)                timer_r <= 16'h0000;
         else if (tick && timer_r != 16'hFFFF)    timer_r <= timer_r + 16'h0001;
      end
   end

   // a channel write during turn-up is served once the path is active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)                 tune_pend_r <= 1'b0;
      else if (chan_wr)             tune_pend_r <= 1'b1;
      else if (state_nxt == ST_TUNE) tune_pend_r <= 1'b0;
   end

   assign lane_state          = state_r;
   assign reset_state_flag    = (state_r == ST_MGMT_INIT);
   assign lowpower_state_flag = (state_r == ST_LOW_PWR);

   // ----------------------------------------------------------------
   // transmit enable
   // ----------------------------------------------------------------
   mmst_ms_t tx_cnt_r;
   wire tx_allow = (state_r == ST_ACTIVE) & ~ctrl_r.tx_disable &
                   (ctrl_r.tx_squelch_dis | ~tx_los_s);
   wire tx_ramped = (tx_cnt_r == `MMST_TX_RAMP_MS);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt_r      <= 16'h0000;
         tx_optical_en <= 1'b0;
      end else begin
         if (!tx_allow)              tx_cnt_r <= 16'h0000;
         else if (tick && !tx_ramped) tx_cnt_r <= tx_cnt_r + 16'h0001;
         tx_optical_en <= tx_allow & tx_ramped;
      end
   end

   // ----------------------------------------------------------------
   // receive output
   // ----------------------------------------------------------------
   mmst_ms_t rx_cnt_r;
   wire rx_cond = (state_r == ST_ACTIVE) & ~receive_signal_loss_s;
   assign rx_valid = (rx_cnt_r == `MMST_RX_LOCK_MS);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_cnt_r  <= 16'h0000;
         rx_out_en <= 1'b0;
      end else begin
         if (!rx_cond)               rx_cnt_r <= 16'h0000;
         else if (tick && !rx_valid) rx_cnt_r <= rx_cnt_r + 16'h0001;
         rx_out_en <= ~ctrl_r.rx_out_dis & (state_r == ST_ACTIVE) &
                      (ctrl_r.rx_squelch_dis | rx_valid);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_lowpwr_entry:  assert property (high_pwr && lp_req && !mod_rst |=> state_r == ST_PWR_DN)
      else $error("low-power request did not start power down");
   a_pwrdn_bound:   assert property (state_r == ST_PWR_DN |-> timer_r < `MMST_PWR_DN_MS)
      else $error("power down overran its limit");
   a_tx_off_fast:   assert property (ctrl_r.tx_disable |=> !tx_optical_en)
      else $error("transmitter stayed on while disabled");
   a_tx_ramp_time:  assert property (tx_allow && tick && tx_cnt_r == `MMST_TX_RAMP_MS - 16'h0001
                                     ##1 tx_allow |=> tx_optical_en)
      else $error("transmitter did not come on after ramp");
   a_tune_bound:    assert property (state_r == ST_TUNE |-> timer_r < `MMST_TUNE_MS)
      else $error("wavelength change overran its limit");
   a_rst_filter:    assert property (rst_pin_s && !mod_rst ##1 !rst_pin_s
                                     |-> state_r != ST_MGMT_INIT || $past(state_r) == ST_MGMT_INIT)
      else $error("short reset pulse reset the module");
   a_init_bound:    assert property (state_r == ST_MGMT_INIT |-> timer_r < `MMST_MGMT_INIT_MS)
      else $error("management init overran its limit");
   a_irq_on_flag:   assert property ($rose(receive_signal_loss_s) && !mask_r[0]
                                     |=> flag_r[0] && !irq_out_low)
      else $error("signal loss not flagged with interrupt");
   a_read_clears:   assert property (flag_rd && flag_ev == 4'h0 ##1 1'b1
                                     |-> flag_r == 4'h0 && irq_out_low)
      else $error("flag read did not clear flags and interrupt");
   a_flag_sticky:   assert property (flag_r[1] && !flag_rd |=> flag_r[1])
      else $error("latched flag dropped without a read");
   a_mask_blocks:   assert property ((flag_nxt & ~mask_r) == 4'h0 |=> irq_out_low)
      else $error("masked flag drove interrupt");
   a_rx_squelch:    assert property (receive_signal_loss_s && !ctrl_r.rx_squelch_dis ##1 receive_signal_loss_s
                                     |=> !rx_out_en)
      else $error("receive output not squelched on loss");
   a_rx_disable:    assert property (ctrl_r.rx_out_dis |=> !rx_out_en)
      else $error("receive output on while disabled");
   a_pwrup_bound:   assert property (state_r == ST_PWR_UP |-> timer_r < `MMST_PWR_UP_MS)
      else $error("power up overran its limit");
   a_rx_lock_bound: assert property (rx_cond && !ctrl_r.rx_out_dis && rx_valid
                                     |=> rx_out_en)
      else $error("receive output not valid after lock");

   // ----------------------------------------------------------------
   // lane path state limits
   // ----------------------------------------------------------------
   // the advertised maxima are only worth something if the states keep them

   a_init_path_lim: assert property (state_r == ST_PATH_INIT |-> timer_r < `MMST_PATH_INIT_MS)
      else $error("path init overran its limit");

   a_deinit_lim:    assert property (state_r == ST_PATH_DEINIT
                                     |-> timer_r < `MMST_PATH_DEINIT_MS)
      else $error("path deinit overran its limit");

   a_tx_on_lim:     assert property (state_r == ST_TX_ON |-> timer_r < `MMST_TX_ON_MS)
      else $error("transmitter turn-on overran its limit");

   a_tx_off_lim:    assert property (state_r == ST_TX_OFF |-> timer_r < `MMST_TX_OFF_MS)
      else $error("transmitter turn-off overran its limit");


   c_path_active:   cover property (state_r == ST_TX_ON ##1 state_r == ST_ACTIVE);
   c_flag_cleared:  cover property (flag_r != 4'h0 && flag_rd ##1 flag_r == 4'h0);
   c_tune_done:     cover property (state_r == ST_TUNE ##1 state_r == ST_TX_ON);
   c_lowpwr_reach:  cover property (state_r == ST_PWR_DN ##1 state_r == ST_LOW_PWR);

endmodule

//--- rtl/mmst_consts.svh
`ifndef MMST_CONSTS_SVH
`define MMST_CONSTS_SVH
// Operation
// - low-power entry completes within 500 ms
// - transmitter off within 100 ms of disable
// - transmitter on within 400 ms of enable
// - warm start reaches path active within 180 s
// - cold start reaches path active within 200 s
// - wavelength change with turn-up within 50 s
// - receiver up 10 s after loss, 200 s cold
// - management init finishes within 2000 ms
// - interrupt asserts within 200 ms of event
// - flag read clears; interrupt releases within 500 us
// - signal loss sets flag, interrupt within 100 ms
// - any flag and interrupt within 1 s
// - mask gates interrupt within 100 ms both ways
// - receive squelch follows input loss within 500 ms
// - receive output disable acts within 500 ms
// - squelch disable acts within 500 ms
// - power-up state lasts at most 180 s
// - advertised path init maximum 10 to 60 s
// - advertised path deinit maximum 1 to 5 s
// - advertised tx on/off maxima in range
// - valid receive signal 8 s after loss clears

// ----------------------------------------------------------------
// clock and timebase
// ----------------------------------------------------------------
`define MMST_CLK_MHZ        100
`define MMST_TICK_US        1000
`define MMST_RST_MIN_US     10

// ----------------------------------------------------------------
// state durations, tx ramp and rx lock times in ms ticks
// ----------------------------------------------------------------
`define MMST_MGMT_INIT_MS   16'd1000
`define MMST_PWR_UP_MS      16'd1000
`define MMST_PATH_INIT_MS   16'd10000
`define MMST_PATH_DEINIT_MS 16'd1000
`define MMST_TX_ON_MS       16'd300
`define MMST_TX_OFF_MS      16'd10
`define MMST_TUNE_MS        16'd5000
`define MMST_PWR_DN_MS      16'd400
`define MMST_TX_RAMP_MS     16'd300
`define MMST_RX_LOCK_MS     16'd2000

// ----------------------------------------------------------------
// advertised maxima: init s, deinit s, tx on 10 ms units, tx off ms
// ----------------------------------------------------------------
`define MMST_ADV_INIT_S     8'd60
`define MMST_ADV_DEINIT_S   8'd5
`define MMST_ADV_TXON_10MS  8'd100
`define MMST_ADV_TXOFF_MS   8'd50

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define MMST_OFF_STATUS     8'h00
`define MMST_OFF_FLAGS      8'h04
`define MMST_OFF_MASK       8'h08
`define MMST_OFF_CTRL       8'h0C
`define MMST_OFF_CHANNEL    8'h10
`define MMST_OFF_ADV        8'h14
`define MMST_RST_MASK       4'h0
`define MMST_RST_CTRL       6'h00
`define MMST_RST_CHANNEL    8'h00
`define MMST_FLG_RECEIVE_SIGNAL_LOSS     0
`define MMST_FLG_TX_FAULT   1
`define MMST_FLG_STATE_CHG  2
`define MMST_FLG_TX_LOS     3
`endif

//--- rtl/mmst_pkg.sv
package mmst_pkg;

   // gray codes along power-up path, except the two-bit ST_MGMT_INIT to ST_PWR_UP step
   typedef enum logic [3:0] {
      ST_MGMT_INIT   = 4'h0,
      ST_LOW_PWR     = 4'h1,
      ST_PWR_UP      = 4'h3,
      ST_PATH_INIT   = 4'h2,
      ST_TX_ON       = 4'h6,
      ST_ACTIVE      = 4'h7,
      ST_TX_OFF      = 4'h5,
      ST_PATH_DEINIT = 4'h4,
      ST_PATH_OFF    = 4'hC,
      ST_TUNE        = 4'hD,
      ST_PWR_DN      = 4'hF
   } mmst_state_e;

   typedef struct packed {
      logic path_deinit;
      logic tx_squelch_dis;
      logic rx_squelch_dis;
      logic rx_out_dis;
      logic tx_disable;
      logic forced_lowpower_ctrl;
   } mmst_ctrl_s;

   typedef logic [3:0]  mmst_flag_t;
   typedef logic [15:0] mmst_ms_t;

endpackage

//--- bench/mmst_host_model.sv
module mmst_host_model (
   input  wire logic pclk,
   output logic      lowpower_request_pin_n,
   output logic      module_rst_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      lowpower_request_pin_n = 1'b1;
      module_rst_pin_n       = 1'b1;
   end

   // ----------------------------------------------------------------
   // host pin requests
   // ----------------------------------------------------------------
   task automatic set_lowpower(input logic req);
      @(posedge pclk);
      lowpower_request_pin_n <= ~req;
   endtask

   // pulses below the minimum only when a scenario wants one refused
   task automatic pulse_reset(input int cycles);
      @(posedge pclk);
      module_rst_pin_n <= 1'b0;
      repeat (cycles) @(posedge pclk);
      module_rst_pin_n <= 1'b1;
   endtask
endmodule

//--- bench/module_mgmt_state_timing_bench.sv
`include "mmst_consts.svh"

module module_mgmt_state_timing_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mmst_pkg::*;

   // short ms tick keeps second-long states inside the run budget
   localparam int MS = 2;
   localparam int O_IRQ = 0;
   localparam int O_TX = 1;
   localparam int O_RX = 2;
   localparam int O_RST = 3;
   localparam int O_LP = 4;
   localparam logic [31:0] FLG_EXP [3] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0008};

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  cond;
   logic        irq_out_low, tx_optical_en, rx_out_en, reset_state_flag, lowpower_state_flag;
   logic        lp_n, mrst_n;
   logic [4:0]  obs;
   mmst_state_e lane_state;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          cyc = 0;

   assign obs = {lowpower_state_flag, reset_state_flag, rx_out_en, tx_optical_en, irq_out_low};

   mmst_top #(.MS_CYCLES(MS)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lowpower_request_pin_n(lp_n), .module_rst_pin_n(mrst_n),
      .receive_signal_loss_in(cond[0]), .tx_fault_in(cond[1]), .tx_los_in(cond[2]),
      .irq_out_low(irq_out_low), .tx_optical_en(tx_optical_en), .rx_out_en(rx_out_en),
      .reset_state_flag(reset_state_flag), .lowpower_state_flag(lowpower_state_flag),
      .lane_state(lane_state));

   mmst_host_model u_host (.pclk(pclk), .lowpower_request_pin_n(lp_n), .module_rst_pin_n(mrst_n));

   // ----------------------------------------------------------------
   // clock, watchdog, verdict
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic report_and_stop();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // access and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, rd, e);
      chk({31'b0, e}, 32'h0000_0000);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic e;
      apb(1'b0, a, 32'h0000_0000, rd, e);
      chk(rd, exp);
   endtask

   // limits are the documented maxima in cycles, except the 50 ms ST_TUNE entry wait and the 4-cycle reset-flag wait
   task automatic wait_obs(input int idx, input logic v, input int lim);
      int n;
      n = 0;
      while (obs[idx] !== v && n < lim) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk({31'b0, obs[idx]}, {31'b0, v});
   endtask

   task automatic hold_obs(input int idx, input logic v, input int len);
      logic ok;
      ok = 1'b1;
      repeat (len) begin
         @(posedge pclk);
         #1;
         if (obs[idx] !== v) ok = 1'b0;
      end
      chk({31'b0, ok}, 32'h0000_0001);
   endtask

   task automatic wait_state(input mmst_state_e s, input int lim);
      int n;
      n = 0;
      while (lane_state !== s && n < lim) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk({28'b0, lane_state}, {28'b0, s});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic e;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      cond = 3'b000;
      repeat (20) @(posedge pclk);
      #1;
      chk({27'b0, obs}, 32'h0000_0009);
      chk({28'b0, lane_state}, {28'b0, ST_MGMT_INIT});
      @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`MMST_OFF_MASK, 32'h0000_0000);
      rd_chk(`MMST_OFF_CTRL, 32'h0000_0000);
      rd_chk(`MMST_OFF_CHANNEL, 32'h0000_0000);
      wr(`MMST_OFF_ADV, 32'h0000_0000);
      rd_chk(`MMST_OFF_ADV, 32'h3264_053C);
      apb(1'b0, 8'h18, 32'h0000_0000, rd, e);
      chk({31'b0, e}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      wait_obs(O_RST, 1'b0, 2000 * MS + 8);
      wait_state(ST_ACTIVE, 200000 * MS);
      wait_obs(O_TX, 1'b1, 400 * MS);
      wait_obs(O_RX, 1'b1, 8000 * MS);
      rd_chk(`MMST_OFF_FLAGS, 32'h0000_0004);
      wait_obs(O_IRQ, 1'b1, MS / 2 + 1);
      rd_chk(`MMST_OFF_FLAGS, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         @(posedge pclk);
         cond[i] <= 1'b1;
         wait_obs(O_IRQ, 1'b0, 100 * MS);
         if (i == 0) wait_obs(O_RX, 1'b0, 500 * MS);
         @(posedge pclk);
         cond[i] <= 1'b0;
         repeat (10) @(posedge pclk);
         rd_chk(`MMST_OFF_FLAGS, FLG_EXP[i]);
         wait_obs(O_IRQ, 1'b1, MS / 2 + 1);
      end
      wait_obs(O_RX, 1'b1, 8000 * MS);
      wait_obs(O_TX, 1'b1, 400 * MS);
      wr(`MMST_OFF_MASK, 32'h0000_0002);
      rd_chk(`MMST_OFF_MASK, 32'h0000_0002);
      @(posedge pclk);
      cond[1] <= 1'b1;
      hold_obs(O_IRQ, 1'b1, 100 * MS);
      wr(`MMST_OFF_MASK, 32'h0000_0000);
      wait_obs(O_IRQ, 1'b0, 100 * MS);
      @(posedge pclk);
      cond[1] <= 1'b0;
      rd_chk(`MMST_OFF_FLAGS, 32'h0000_0002);
      wr(`MMST_OFF_CTRL, 32'h0000_0018);
      repeat (500 * MS) @(posedge pclk);
      cond <= 3'b101;
      hold_obs(O_RX, 1'b1, 50);
      hold_obs(O_TX, 1'b1, 50);
      @(posedge pclk);
      cond <= 3'b000;
      wr(`MMST_OFF_CTRL, 32'h0000_0000);
      rd_chk(`MMST_OFF_FLAGS, 32'h0000_0009);
      wait_obs(O_RX, 1'b1, 8000 * MS);
      wr(`MMST_OFF_CTRL, 32'h0000_0004);
      wait_obs(O_RX, 1'b0, 500 * MS);
      wr(`MMST_OFF_CTRL, 32'h0000_0000);
      wait_obs(O_RX, 1'b1, 500 * MS);
      wr(`MMST_OFF_CTRL, 32'h0000_0002);
      wait_obs(O_TX, 1'b0, 100 * MS);
      wr(`MMST_OFF_CTRL, 32'h0000_0000);
      wait_obs(O_TX, 1'b1, 400 * MS);
      wr(`MMST_OFF_CHANNEL, 32'h0000_002A);
      wait_state(ST_TUNE, 50 * MS);
      wait_state(ST_ACTIVE, 50000 * MS);
      rd_chk(`MMST_OFF_CHANNEL, 32'h0000_002A);
      rd_chk(`MMST_OFF_FLAGS, 32'h0000_0004);
      wr(`MMST_OFF_CTRL, 32'h0000_0001);
      wait_obs(O_LP, 1'b1, 500 * MS);
      u_host.set_lowpower(1'b1);
      repeat (4) @(posedge pclk);
      wr(`MMST_OFF_CTRL, 32'h0000_0000);
      hold_obs(O_LP, 1'b1, 100);
      u_host.set_lowpower(1'b0);
      wait_state(ST_ACTIVE, 180000 * MS);
      u_host.pulse_reset(500);
      hold_obs(O_RST, 1'b0, 20);
      u_host.pulse_reset(1100);
      wait_obs(O_RST, 1'b1, 4);
      wait_obs(O_RST, 1'b0, 2000 * MS + 8);
      report_and_stop();
   end
endmodule
